// file: hw/ppr_defs.vh
// Constants for the parallel port mode router
`ifndef PPR_DEFS_VH
`define PPR_DEFS_VH

// Function select codes
`define PPR_F_PAR        4'h0
`define PPR_F_SER        4'h1
`define PPR_F_TUNE       4'h2
`define PPR_F_TUNE_SWAP  4'h3
`define PPR_F_PHASE_AMP  4'h4
`define PPR_F_AMP_PHASE  4'h5
`define PPR_F_HI_AMPH    4'h6
`define PPR_F_HI_POWH    4'h7
`define PPR_F_HI_AMPL    4'h8
`define PPR_F_HI_POWL    4'h9
`define PPR_F_LO_AMPH    4'hA
`define PPR_F_LO_POWH    4'hB
`define PPR_F_LO_AMPL    4'hC
`define PPR_F_LO_POWL    4'hD
`define PPR_F_LAST_DIR   4'hD

// Register offsets
`define PPR_OFS_CTRL     8'h00
`define PPR_OFS_TUNE     8'h04
`define PPR_OFS_PHAMP    8'h08
`define PPR_OFS_STATUS   8'h0C

// Control register fields and reset value
`define PPR_CTRL_PD_STYLE 3
`define PPR_CTRL_AMP_KEY  8
`define PPR_CTRL_STREAM   17
`define PPR_CTRL_MASK     32'h0002_0108
`define PPR_CTRL_RESET    32'h0000_0008

// Word widths
`define PPR_TUNE_W       32
`define PPR_PHASE_W      16
`define PPR_AMP_W        16
`define PPR_AMP_USED     12
`define PPR_BUF_W        60

`endif

// file: hw/ppr_buf.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module ppr_buf #(
	parameter WIDTH = 60
) (
	// Clock and reset
	input  wire             clk_sys,
	input  wire             rst_b,
	// Fill side
	input  wire             in_valid,
	input  wire [WIDTH-1:0] in_data,
	output reg              in_ready,
	// Drain side
	output reg              out_valid,
	output wire [WIDTH-1:0] out_data,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem [0:1];
	reg             wr_ptr;
	reg             rd_ptr;
	reg [1:0]       count;
	wire            push;
	wire            pop;
	reg  [1:0]      next_count;

	assign push     = in_valid & in_ready;
	assign pop      = out_valid & out_ready;
	assign out_data = mem[rd_ptr];

	always @* begin
		next_count = count;
		if (push & ~pop)
			next_count = count + 2'h1;
		else if (pop & ~push)
			next_count = count - 2'h1;
	end

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr    <= 1'b0;
			rd_ptr    <= 1'b0;
			count     <= 2'h0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			count     <= next_count;
			in_ready  <= (next_count != 2'h2);
			out_valid <= (next_count != 2'h0);
		end
	end

	always @(posedge clk_sys) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule

// file: hw/ppr_route.v
// Maps a direct-mode port word onto tuning, phase and amplitude words
`timescale 1ns/1ns
`include "ppr_defs.vh"
module ppr_route (
	// Select and port word
	input  wire [3:0]  func_sel,
	input  wire [31:0] port_data,
	// Present holding words
	input  wire [31:0] cur_tune,
	input  wire [15:0] cur_phase,
	input  wire [15:0] cur_amp,
	// Merged words
	output reg  [31:0] next_tune,
	output reg  [15:0] next_phase,
	output reg  [15:0] next_amp,
	output wire        is_direct
);
	// Direct modes are 0010 through 1101
	function dir_code;
		input [3:0] f;
		begin
			dir_code = (f >= `PPR_F_TUNE) && (f <= `PPR_F_LAST_DIR);
		end
	endfunction

	assign is_direct = dir_code(func_sel);

	always @* begin
		next_tune  = cur_tune;
		next_phase = cur_phase;
		next_amp   = cur_amp;
		if (func_sel >= `PPR_F_HI_AMPH && func_sel <= `PPR_F_HI_POWL)
			next_tune[31:8] = port_data[31:8];
		else if (func_sel >= `PPR_F_LO_AMPH && func_sel <= `PPR_F_LO_POWL)
			next_tune[23:0] = port_data[31:8];
		case (func_sel)
			`PPR_F_TUNE: begin
				next_tune = port_data;
			end
			`PPR_F_TUNE_SWAP: begin
				next_tune = {port_data[15:0], port_data[31:16]};
			end
			`PPR_F_PHASE_AMP: begin
				next_phase = port_data[31:16];
				next_amp   = {4'h0, port_data[11:0]};
			end
			`PPR_F_AMP_PHASE: begin
				next_amp   = {4'h0, port_data[27:16]};
				next_phase = port_data[15:0];
			end
			`PPR_F_HI_AMPH, `PPR_F_LO_AMPH: begin
				next_amp[15:8] = port_data[7:0];
			end
			`PPR_F_HI_POWH, `PPR_F_LO_POWH: begin
				next_phase[15:8] = port_data[7:0];
			end
			`PPR_F_HI_AMPL, `PPR_F_LO_AMPL: begin
				next_amp[7:0] = port_data[7:0];
			end
			`PPR_F_HI_POWL, `PPR_F_LO_POWL: begin
				next_phase[7:0] = port_data[7:0];
			end
			default: begin
				next_tune = cur_tune;
			end
		endcase
	end
endmodule

// file: hw/ppr_top.v
// Parallel port mode router: port decode, holding words, core feed, registers
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`include "ppr_defs.vh"
module ppr_top (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        rst_b,
	// Host port
	input  wire [3:0]  func_sel,
	input  wire [31:0] port_data,
	input  wire        port_valid,
	input  wire        io_update,
	output reg         port_ready,
	// Parallel programming outputs
	output reg         prog_active,
	output reg  [15:0] prog_data,
	output reg  [7:0]  prog_addr,
	output reg  [7:0]  prog_ctrl,
	// Serial programming outputs
	output reg         ser_active,
	output reg  [7:0]  ser_lines,
	// Synthesis core feed
	input  wire        core_ready,
	output reg         core_load,
	output reg  [31:0] core_tune,
	output reg  [15:0] core_phase,
	output reg  [11:0] core_amp,
	output reg         core_amp_en,
	// Power-down
	input  wire        external_powerdown_pin,
	output reg         pd_full,
	output reg         pd_fast,
	output reg         pll_hold_lock,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata
);
	reg  [31:0] first_control_register;
	reg  [31:0] hold_tune;
	reg  [15:0] hold_phase;
	reg  [15:0] hold_amp;
	reg         upd_pending;
	wire [31:0] next_tune;
	wire [15:0] next_phase;
	wire [15:0] next_amp;
	wire        is_direct;
	wire        stream_on;
	wire        buf_in_ready;
	wire        buf_out_valid;
	wire [59:0] buf_out_data;
	wire        take_word;
	reg         buf_push;
	reg  [59:0] buf_word;
	wire        core_pop;

	assign stream_on = first_control_register[`PPR_CTRL_STREAM];
	assign take_word = port_valid & is_direct & buf_in_ready;
	assign core_pop  = buf_out_valid & core_ready;

	ppr_route u_route (
		.func_sel  (func_sel),
		.port_data (port_data),
		.cur_tune   (hold_tune),
		.cur_phase  (hold_phase),
		.cur_amp    (hold_amp),
		.next_tune  (next_tune),
		.next_phase (next_phase),
		.next_amp  (next_amp),
		.is_direct (is_direct)
	);

	// Word going into the buffer: merged word when streaming, else holding
	always @* begin
		buf_push = 1'b0;
		buf_word = {hold_tune, hold_phase, hold_amp[11:0]};
		if (stream_on & take_word) begin
			buf_push = 1'b1;
			buf_word = {next_tune, next_phase, next_amp[11:0]};
		end else if (upd_pending) begin
			buf_push = 1'b1;
		end
	end

	ppr_buf #(
		.WIDTH (`PPR_BUF_W)
	) u_buf (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.in_valid  (buf_push),
		.in_data   (buf_word),
		.in_ready  (buf_in_ready),
		.out_valid (buf_out_valid),
		.out_data  (buf_out_data),
		.out_ready (core_ready)
	);

	// Holding words and transfer request
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hold_tune   <= 32'h0000_0000;
			hold_phase  <= 16'h0000;
			hold_amp    <= 16'h0000;
			upd_pending <= 1'b0;
		end else begin
			if (take_word) begin
				hold_tune  <= next_tune;
				hold_phase <= next_phase;
				hold_amp <= next_amp;
			end
			// New strobe wins over the clear of an earlier one
			if (io_update & ~stream_on)
				upd_pending <= 1'b1;
			else if (buf_push & buf_in_ready)
				upd_pending <= 1'b0;
		end
	end

	// Programming mode outputs
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prog_active <= 1'b0;
			prog_data   <= 16'h0000;
			prog_addr   <= 8'h00;
			prog_ctrl   <= 8'h00;
			ser_active  <= 1'b0;
			ser_lines   <= 8'h00;
			port_ready  <= 1'b1;
		end else begin
			port_ready  <= buf_in_ready;
			prog_active <= (func_sel == `PPR_F_PAR);
			ser_active  <= (func_sel == `PPR_F_SER);
			if (func_sel == `PPR_F_PAR) begin
				prog_data <= port_data[31:16];
				prog_addr <= port_data[15:8];
				prog_ctrl <= port_data[7:0];
			end
			if (func_sel == `PPR_F_SER)
				ser_lines <= port_data[7:0];
		end
	end

	// Core words updated only from the buffer; amplitude enable follows the control register
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			core_load   <= 1'b0;
			core_tune   <= 32'h0000_0000;
			core_phase  <= 16'h0000;
			core_amp    <= 12'h000;
			core_amp_en <= 1'b0;
		end else begin
			core_load   <= core_pop;
			core_amp_en <= first_control_register[`PPR_CTRL_AMP_KEY];
			if (core_pop) begin
				core_tune  <= buf_out_data[59:28];
				core_phase <= buf_out_data[27:12];
				core_amp <= buf_out_data[11:0];
			end
		end
	end

	// Power-down steering
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pd_full       <= 1'b0;
			pd_fast       <= 1'b0;
			pll_hold_lock <= 1'b1;
		end else begin
			pd_full       <= external_powerdown_pin & first_control_register[`PPR_CTRL_PD_STYLE];
			pd_fast       <= external_powerdown_pin & ~first_control_register[`PPR_CTRL_PD_STYLE];
			pll_hold_lock <= ~(external_powerdown_pin & first_control_register[`PPR_CTRL_PD_STYLE]);
		end
	end

	// Register port
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			first_control_register <= `PPR_CTRL_RESET;
			reg_rdata              <= 32'h0000_0000;
		end else begin
			if (reg_wr && reg_addr == `PPR_OFS_CTRL)
				first_control_register <= reg_wdata & `PPR_CTRL_MASK;
			reg_rdata <= 32'h0000_0000;
			if (reg_rd) begin
				case (reg_addr)
					`PPR_OFS_CTRL: begin
						reg_rdata <= first_control_register;
					end
					`PPR_OFS_TUNE: begin
						reg_rdata <= core_tune;
					end
					`PPR_OFS_PHAMP: begin
						reg_rdata <= {core_phase, 4'h0, core_amp};
					end
					`PPR_OFS_STATUS: begin
						reg_rdata <= {24'h00_0000, func_sel, upd_pending, pd_fast, pd_full, port_ready};
					end
					default: begin
						reg_rdata <= 32'h0000_0000;
					end
				endcase
			end
		end
	end
endmodule

// file: dv/ppr_chk.sv
// Port assertions for the parallel port mode router
`timescale 1ns/1ns
module ppr_chk (
	// Clock, reset and host port
	input wire        clk_sys,
	input wire        rst_b,
	input wire [3:0]  func_sel,
	input wire [31:0] port_data,
	input wire        external_powerdown_pin,
	input wire        reg_rd,
	// Watched outputs
	input wire        prog_active,
	input wire [15:0] prog_data,
	input wire [7:0]  prog_addr,
	input wire [7:0]  prog_ctrl,
	input wire        ser_active,
	input wire [7:0]  ser_lines,
	input wire        core_load,
	input wire [31:0] core_tune,
	input wire [15:0] core_phase,
	input wire [11:0] core_amp,
	input wire        pd_full,
	input wire        pd_fast,
	input wire        pll_hold_lock,
	input wire [31:0] reg_rdata
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	a_prog_active: assert property (func_sel == 4'h0 |=> prog_active && !ser_active)
		else $error("parallel mode flag wrong");
	a_prog_fields: assert property (func_sel == 4'h0 |=> {prog_data, prog_addr, prog_ctrl} == $past(port_data))
		else $error("parallel fields wrong");
	a_ser_lines: assert property (func_sel == 4'h1 |=> ser_active && ser_lines == $past(port_data[7:0]))
		else $error("serial lines wrong");
	a_fast_lock: assert property (pd_fast |-> pll_hold_lock && !pd_full)
		else $error("lock lost in fast power-down");
	a_full_unlock: assert property (pd_full |-> !pll_hold_lock)
		else $error("lock held in full power-down");
	a_pin_idle: assert property (!external_powerdown_pin |=> !pd_fast && !pd_full)
		else $error("power-down without pin");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data without read");
	a_core_hold: assert property (!core_load |-> $stable({core_tune, core_phase, core_amp}))
		else $error("tuning word moved without load");
endmodule
bind ppr_top ppr_chk u_chk (.clk_sys, .rst_b, .func_sel, .port_data, .external_powerdown_pin, .reg_rd,
	.prog_active, .prog_data, .prog_addr, .prog_ctrl, .ser_active, .ser_lines, .core_load, .core_tune,
	.core_phase, .core_amp, .pd_full, .pd_fast, .pll_hold_lock, .reg_rdata);

// file: dv/ppr_host.sv
// Host model driving select pins, port word and transfer strobe
`timescale 1ns/1ns
module ppr_host (
	// Clock
	input  wire        clk_sys,
	// Port pins
	output reg  [3:0]  func_sel,
	output reg  [31:0] port_data,
	output reg         port_valid,
	output reg         io_update
);
	initial begin
		func_sel = 4'hF;
		port_data = 32'h0;
		port_valid = 1'b0;
		io_update = 1'b0;
	end
	task send(input [3:0] f, input [31:0] d);
		@(posedge clk_sys);
		func_sel <= f;
		port_data <= d;
		port_valid <= (f > 4'h1);
		@(posedge clk_sys);
		port_valid <= 1'b0;
		port_data <= ~d;
	endtask
	task pulse;
		@(posedge clk_sys);
		io_update <= 1'b1;
		@(posedge clk_sys);
		io_update <= 1'b0;
	endtask
endmodule

// file: dv/parallel_port_mode_router_test.sv
// Self-checking bench for the parallel port mode router
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("unexpected %s exp %h got %h", n, e, g); end end
module parallel_port_mode_router_test;
	reg clk_sys = 1'b0;
	reg rst_b = 1'b0;
	reg core_ready = 1'b1;
	reg external_powerdown_pin = 1'b0;
	reg [7:0] reg_addr = 8'h00;
	reg [31:0] reg_wdata = 32'h0;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	wire [3:0] func_sel;
	wire [31:0] port_data, core_tune, reg_rdata;
	wire [15:0] prog_data, core_phase;
	wire [7:0] prog_addr, prog_ctrl, ser_lines;
	wire [11:0] core_amp;
	wire port_valid, io_update, port_ready, prog_active, ser_active, core_load, core_amp_en, pd_full, pd_fast, pll_hold_lock;
	reg [31:0] e_tune = 32'h0, q;
	reg [15:0] e_phase = 16'h0, e_amp = 16'h0;
	int error_cnt = 0, checked = 0, nload = 0, n;
	ppr_host host (.clk_sys, .func_sel, .port_data, .port_valid, .io_update);
	ppr_top dut (.clk_sys, .rst_b, .func_sel, .port_data, .port_valid, .io_update, .port_ready, .prog_active,
		.prog_data, .prog_addr, .prog_ctrl, .ser_active, .ser_lines, .core_ready, .core_load, .core_tune,
		.core_phase, .core_amp, .core_amp_en, .external_powerdown_pin, .pd_full, .pd_fast, .pll_hold_lock,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	initial forever #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (core_load === 1'b1) nload <= nload + 1;
	task finish_test;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task wr(input [7:0] a, input [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	task rd(input [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		q = reg_rdata;
	endtask
	task merge(input [3:0] f, input [31:0] d);
		case (f)
		4'h2: e_tune = d;
		4'h3: e_tune = {d[15:0], d[31:16]};
		4'h4: {e_phase, e_amp} = {d[31:16], 4'h0, d[11:0]};
		4'h5: {e_amp, e_phase} = {4'h0, d[27:0]};
		default: if (f > 4'h5 && f < 4'hE) begin
			if (f < 4'hA) e_tune[31:8] = d[31:8];
			else e_tune[23:0] = d[31:8];
			case (f[1:0])
			2'h2: e_amp[15:8] = d[7:0];
			2'h3: e_phase[15:8] = d[7:0];
			2'h0: e_amp[7:0] = d[7:0];
			default: e_phase[7:0] = d[7:0];
			endcase
		end
		endcase
	endtask
	task wait_load;
		repeat (12) if (nload == n) @(negedge clk_sys);
		`CHK("core_load", 1'b1, nload > n)
		`CHK("core_tune", e_tune, core_tune)
		`CHK("core_phase", e_phase, core_phase)
		`CHK("core_amp", e_amp[11:0], core_amp)
	endtask
	task t_regs;
		rd(8'h00);
		`CHK("ctrl", 32'h8, q)
		wr(8'h00, 32'hFFFF_FFFF);
		rd(8'h00);
		`CHK("ctrl", 32'h0002_0108, q)
		rd(8'h10);
		`CHK("unmapped", 32'h0, q)
		@(posedge clk_sys);
		external_powerdown_pin <= 1'b1;
		wr(8'h00, 32'h0002_0100);
		@(negedge clk_sys);
		`CHK("amp_en", 1'b1, core_amp_en)
		`CHK("pd_fast", 3'b110, {pd_fast, pll_hold_lock, pd_full})
		wr(8'h00, 32'h0002_0008);
		@(negedge clk_sys);
		`CHK("pd_full", 3'b001, {pd_fast, pll_hold_lock, pd_full})
		`CHK("amp_en", 1'b0, core_amp_en)
		@(posedge clk_sys);
		external_powerdown_pin <= 1'b0;
		wr(8'h00, 32'h0002_0100);
		$display("register test done");
	endtask
	task t_direct;
		for (int f = 2; f < 14; f++) begin
			n = nload;
			host.send(f[3:0], 32'h9E37_79B9 ^ {8{f[3:0]}});
			merge(f[3:0], 32'h9E37_79B9 ^ {8{f[3:0]}});
			wait_load;
		end
		rd(8'h04);
		`CHK("tune_reg", e_tune, q)
		rd(8'h08);
		`CHK("phase_amp_reg", {e_phase, 4'h0, e_amp[11:0]}, q)
		n = nload;
		host.send(4'hE, 32'h1111_2222);
		host.send(4'hF, 32'h3333_4444);
		repeat (6) @(negedge clk_sys);
		`CHK("ignored", n, nload)
		`CHK("core_tune", e_tune, core_tune)
		$display("direct test done");
	endtask
	task t_update;
		wr(8'h00, 32'h0000_0100);
		n = nload;
		host.send(4'h2, 32'hC001_D00D);
		host.send(4'h4, 32'h5A5A_0ABC);
		merge(4'h2, 32'hC001_D00D);
		merge(4'h4, 32'h5A5A_0ABC);
		repeat (6) @(negedge clk_sys);
		`CHK("held", n, nload)
		host.pulse;
		wait_load;
		$display("update test done");
	endtask
	task t_buffer;
		wr(8'h00, 32'h0002_0100);
		n = nload;
		core_ready <= 1'b0;
		host.send(4'h2, 32'h0000_0001);
		host.send(4'h2, 32'h0000_0002);
		host.send(4'h2, 32'h0000_0003);
		@(negedge clk_sys);
		`CHK("port_ready", 1'b0, port_ready)
		@(posedge clk_sys);
		core_ready <= 1'b1;
		repeat (8) @(negedge clk_sys);
		`CHK("loads", n + 2, nload)
		`CHK("core_tune", 32'h2, core_tune)
		$display("buffer test done");
	endtask
	task t_prog;
		host.send(4'h0, 32'hA5C3_7E81);
		@(negedge clk_sys);
		`CHK("prog", 33'h1_A5C3_7E81, {prog_active, prog_data, prog_addr, prog_ctrl})
		host.send(4'h1, 32'hFFFF_FF96);
		@(negedge clk_sys);
		`CHK("serial", 9'h196, {ser_active, ser_lines})
		rd(8'h0C);
		`CHK("status", 32'h0000_0011, q)
		$display("programming test done");
	endtask
	initial begin
		#200000;
		error_cnt++;
		finish_test;
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_regs;
		t_direct;
		t_update;
		t_buffer;
		t_prog;
		finish_test;
	end
endmodule
